// [common/tc_range_map.svh]
// band limits and saturation codes for the thermocouple value encoder
`ifndef TC_RANGE_MAP_SVH
`define TC_RANGE_MAP_SVH
`define TC_CODE_OVERFLOW  16'h7FFF
`define TC_CODE_UNDERFLOW 16'h8000
`define TC_WORD_RESET     16'h0000
`define TC_K_OVR_MAX   16'h3F5C
`define TC_K_RATED_MAX 16'h3598
`define TC_K_UNDR_MAX  16'hF573
`define TC_KN_UFL_MIN  16'hF0C4
`define TC_L_OVR_MAX   16'h2CEC
`define TC_L_RATED_MAX 16'h2328
`define TC_L_UNDR_MAX  16'hF82F
`define TC_L_UFL_MIN   16'hF380
`define TC_N_OVR_MAX   16'h3C8C
`define TC_N_RATED_MAX 16'h32C8
`define TC_N_UNDR_MAX  16'hF573
`define TC_R_OVR_MAX   16'h4EDE
`define TC_R_RATED_MAX 16'h451A
`define TC_R_UNDR_MAX  16'hFE0B
`define TC_R_UFL_MIN   16'hF95C
`define TC_S_OVR_MAX   16'h4844
`define TC_S_RATED_MAX 16'h451A
`define TC_S_UNDR_MAX  16'hFE0B
`define TC_S_UFL_MIN   16'hF95C
`endif

// [common/tc_range_pkg.sv]
// types for the thermocouple value encoder
package tc_range_pkg;
  typedef enum logic [2:0] {
    SENSOR_K = 3'b000,
    SENSOR_L = 3'b001,
    SENSOR_N = 3'b010,
    SENSOR_R = 3'b011,
    SENSOR_S = 3'b100
  } sensor_t;
  typedef enum logic [2:0] {
    BAND_RATED     = 3'b000,
    BAND_OVERRANGE = 3'b001,
    BAND_OVERFLOW  = 3'b010,
    BAND_UNDERRANGE = 3'b011,
    BAND_UNDERFLOW = 3'b100
  } band_t;
  typedef struct packed {
    logic signed [15:0] ovrMax;
    logic signed [15:0] ratedMax;
    logic signed [15:0] undrMax;
    logic signed [15:0] uflMin;
  } limits_t;
endpackage

// [rtl/tc_limit_table.sv]
// limit lookup for the selected thermocouple type
`timescale 1ns/1ps
`default_nettype none
`include "tc_range_map.svh"
module tc_limit_table
  import tc_range_pkg::*;
(
  // selection
  input  wire sensor_t sensorType,
  // limits of that type
  output limits_t      limits
);
  // pure table; the selected row alone reaches the classifier
  always_comb begin
    case (sensorType)
      SENSOR_K: begin
        limits = '{`TC_K_OVR_MAX, `TC_K_RATED_MAX, `TC_K_UNDR_MAX, `TC_KN_UFL_MIN};
      end
      SENSOR_L: begin
        limits = '{`TC_L_OVR_MAX, `TC_L_RATED_MAX, `TC_L_UNDR_MAX, `TC_L_UFL_MIN};
      end
      SENSOR_N: begin
        limits = '{`TC_N_OVR_MAX, `TC_N_RATED_MAX, `TC_N_UNDR_MAX, `TC_KN_UFL_MIN};
      end
      SENSOR_R: begin
        limits = '{`TC_R_OVR_MAX, `TC_R_RATED_MAX, `TC_R_UNDR_MAX, `TC_R_UFL_MIN};
      end
      SENSOR_S: begin
        limits = '{`TC_S_OVR_MAX, `TC_S_RATED_MAX, `TC_S_UNDR_MAX, `TC_S_UFL_MIN};
      end
      default: begin // unused codes fall back to type K
        limits = '{`TC_K_OVR_MAX, `TC_K_RATED_MAX, `TC_K_UNDR_MAX, `TC_KN_UFL_MIN};
      end
    endcase
  end
endmodule
`default_nettype wire

// [rtl/tc_value_encoder.sv]
// thermocouple value range encoder: band classification and saturation
`timescale 1ns/1ps
`default_nettype none
`include "tc_range_map.svh"
module tc_value_encoder
  import tc_range_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // controller selection
  input  wire sensor_t     sensorType,
  // measurement from the converter front end
  input  wire logic        measValid,
  input  wire logic [15:0] measTenths,
  // encoded word to the controller
  output logic             wordValid,
  output logic [15:0]      wordValue,
  output band_t            wordBand
);
  limits_t limits;                    // limits of the selected type
  logic signed [15:0] meas;           // input as signed tenths
  band_t              band_nxt;       // band of current input
  logic [15:0]        value_nxt;      // word to report
  logic               wordValid_r;    // output strobe register
  logic [15:0]        wordValue_r;    // output word register
  band_t              wordBand_r;     // output band register

  assign meas = $signed(measTenths);

  // the table is pure logic, so a type change takes effect on the very next sample
  tc_limit_table tc_limit_table_i (
    .sensorType (sensorType),
    .limits     (limits)
  );

  // classify against the selected type only; selection sampled with each sample
  // overflow is tested first, so the saturation code wins over every band below it;
  // underflow is tested before underrange because its threshold lies inside that band
  always_comb begin
    band_nxt  = BAND_RATED;
    value_nxt = measTenths; // value passes unchanged, slope kept
    if (meas > limits.ovrMax) begin
      // above the top of the overrange band
      band_nxt  = BAND_OVERFLOW;
      value_nxt = `TC_CODE_OVERFLOW;
    end else if (meas > limits.ratedMax) begin
      // no accuracy promised here, the word is passed as measured
      band_nxt = BAND_OVERRANGE;
    end else if (meas < limits.uflMin) begin
      // far below any real reading: treated as a broken input, low code reported
      band_nxt  = BAND_UNDERFLOW;
      value_nxt = `TC_CODE_UNDERFLOW;
    end else if (meas <= limits.undrMax) begin
      // below the rated band, the slope of the curve carries on
      band_nxt = BAND_UNDERRANGE;
    end
  end

  // output strobe follows each accepted sample by one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      wordValid_r <= 1'b0;
    end else begin
      wordValid_r <= measValid;
    end
  end

  // word and band held until the next sample
  always_ff @(posedge clk) begin
    if (reset) begin
      wordValue_r <= `TC_WORD_RESET;
      wordBand_r  <= BAND_RATED;
    end else if (measValid) begin
      wordValue_r <= value_nxt;
      wordBand_r  <= band_nxt;
    end
  end

  assign wordValid = wordValid_r;
  assign wordValue = wordValue_r;
  assign wordBand  = wordBand_r;

  // checks: all but AST_HOLD, AST_RESET_IDLE and the two saturation-code checks look one edge after the sample, when the registered word stands;
  // all are cut off while reset is high, except the one that checks the reset values
  AST_OVERFLOW: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_K && $signed(measTenths) > 16'sh3F5C
    |=> wordValue == 16'h7FFF && wordBand == BAND_OVERFLOW)
    else $error("overflow code missing");
  AST_UNDERFLOW_KN: assert property (@(posedge clk) disable iff (reset)
    measValid && (sensorType == SENSOR_K || sensorType == SENSOR_N)
    && $signed(measTenths) < $signed(16'hF0C4)
    |=> wordValue == 16'h8000 && wordBand == BAND_UNDERFLOW)
    else $error("underflow code missing");
  AST_UNDERFLOW_L: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_L && $signed(measTenths) < $signed(16'hF380)
    |=> wordBand == BAND_UNDERFLOW)
    else $error("type L underflow missing");
  AST_R_UNDERRANGE: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_R && $signed(measTenths) == -16'sd501
    |=> wordBand == BAND_UNDERRANGE && wordValue == 16'hFE0B)
    else $error("type R underrange wrong");
  AST_R_RATED_EDGE: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_R && measTenths == 16'h451A
    |=> wordBand == BAND_RATED)
    else $error("type R rated edge wrong");
  AST_S_OVERRANGE: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_S && measTenths == 16'h451B
    |=> wordBand == BAND_OVERRANGE && wordValue == 16'h451B)
    else $error("type S overrange wrong");
  AST_PASS_THROUGH: assert property (@(posedge clk) disable iff (reset)
    measValid ##1 (wordBand != BAND_OVERFLOW && wordBand != BAND_UNDERFLOW)
    |-> wordValue == $past(measTenths))
    else $error("in-band value altered");
  AST_HOLD: assert property (@(posedge clk) disable iff (reset)
    !measValid |=> $stable(wordValue) && $stable(wordBand) && !wordValid)
    else $error("word changed without sample");
  AST_L_OVERRANGE: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_L && measTenths == 16'h2CEC
    |=> wordBand == BAND_OVERRANGE)
    else $error("type L top limit wrong");


  // strobe, reset values and saturation codes, whatever the type
  AST_VALID_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
    measValid
    |=> wordValid)
    else $error("strobe missing after sample");
  AST_RESET_IDLE: assert property (@(posedge clk)
    reset
    |=> !wordValid && wordValue == 16'h0000 && wordBand == BAND_RATED)
    else $error("outputs not idle after reset");
  AST_SAT_HIGH_CODE: assert property (@(posedge clk) disable iff (reset)
    wordBand == BAND_OVERFLOW
    |-> wordValue == 16'h7FFF)
    else $error("overflow band without overflow code");
  AST_SAT_LOW_CODE: assert property (@(posedge clk) disable iff (reset)
    wordBand == BAND_UNDERFLOW
    |-> wordValue == 16'h8000)
    else $error("underflow band without underflow code");

  // type K: band edges and the kept slope below the linearised part
  AST_K_OVERRANGE_TOP: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_K && measTenths == 16'h3F5C
    |=> wordBand == BAND_OVERRANGE && wordValue == 16'h3F5C)
    else $error("type K overrange top wrong");
  AST_K_OVERRANGE_LOW: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_K && measTenths == 16'h3599
    |=> wordBand == BAND_OVERRANGE)
    else $error("type K overrange bottom wrong");
  AST_K_RATED_TOP: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_K && measTenths == 16'h3598
    |=> wordBand == BAND_RATED && wordValue == 16'h3598)
    else $error("type K rated top wrong");
  AST_K_UNDERRANGE: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_K && measTenths == 16'hF573
    |=> wordBand == BAND_UNDERRANGE && wordValue == 16'hF573)
    else $error("type K underrange top wrong");
  AST_K_SLOPE_KEPT: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_K && $signed(measTenths) >= $signed(16'hF574)
    && $signed(measTenths) <= $signed(16'hF768)
    |=> wordBand == BAND_RATED && wordValue == $past(measTenths))
    else $error("type K low rated value altered");
  AST_KN_UFL_EDGE: assert property (@(posedge clk) disable iff (reset)
    measValid && (sensorType == SENSOR_K || sensorType == SENSOR_N)
    && measTenths == 16'hF0C4
    |=> wordBand == BAND_UNDERRANGE && wordValue == 16'hF0C4)
    else $error("type K/N underflow threshold not exclusive");

  // type L: the top limit is the coded one, not the printed decimal
  AST_L_OVERFLOW: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_L && $signed(measTenths) > 16'sh2CEC
    |=> wordValue == 16'h7FFF && wordBand == BAND_OVERFLOW)
    else $error("type L overflow missing");
  AST_L_RATED_TOP: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_L && measTenths == 16'h2328
    |=> wordBand == BAND_RATED)
    else $error("type L rated top wrong");
  AST_L_UNDERRANGE: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_L && measTenths == 16'hF82F
    |=> wordBand == BAND_UNDERRANGE && wordValue == 16'hF82F)
    else $error("type L underrange top wrong");
  AST_L_RATED_LOW: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_L && measTenths == 16'hF830
    |=> wordBand == BAND_RATED)
    else $error("type L rated bottom wrong");
  AST_L_UFL_EDGE: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_L && measTenths == 16'hF380
    |=> wordBand == BAND_UNDERRANGE && wordValue == 16'hF380)
    else $error("type L underflow threshold not exclusive");
  AST_L_UFL_CODE: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_L && $signed(measTenths) < $signed(16'hF380)
    |=> wordValue == 16'h8000)
    else $error("type L underflow code missing");

  // type N: band edges and the kept slope below the linearised part
  AST_N_OVERFLOW: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_N && $signed(measTenths) > 16'sh3C8C
    |=> wordValue == 16'h7FFF && wordBand == BAND_OVERFLOW)
    else $error("type N overflow missing");
  AST_N_OVERRANGE: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_N && measTenths == 16'h32C9
    |=> wordBand == BAND_OVERRANGE)
    else $error("type N overrange bottom wrong");
  AST_N_UNDERRANGE: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_N && measTenths == 16'hF573
    |=> wordBand == BAND_UNDERRANGE)
    else $error("type N underrange top wrong");
  AST_N_SLOPE_KEPT: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_N && $signed(measTenths) >= $signed(16'hF574)
    && $signed(measTenths) <= $signed(16'hF768)
    |=> wordBand == BAND_RATED && wordValue == $past(measTenths))
    else $error("type N low rated value altered");

  // type R and type S
  AST_R_OVERFLOW: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_R && $signed(measTenths) > 16'sh4EDE
    |=> wordValue == 16'h7FFF && wordBand == BAND_OVERFLOW)
    else $error("type R overflow missing");
  AST_R_UNDERFLOW: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_R && $signed(measTenths) < $signed(16'hF95C)
    |=> wordValue == 16'h8000 && wordBand == BAND_UNDERFLOW)
    else $error("type R underflow missing");
  AST_R_UFL_EDGE: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_R && measTenths == 16'hF95C
    |=> wordBand == BAND_UNDERRANGE && wordValue == 16'hF95C)
    else $error("type R underflow threshold not exclusive");
  AST_S_OVERFLOW: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_S && $signed(measTenths) > 16'sh4844
    |=> wordValue == 16'h7FFF && wordBand == BAND_OVERFLOW)
    else $error("type S overflow missing");
  AST_S_OVERRANGE_TOP: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType == SENSOR_S && measTenths == 16'h4844
    |=> wordBand == BAND_OVERRANGE && wordValue == 16'h4844)
    else $error("type S overrange top wrong");

  // spare type codes must fall back to the type K limits
  AST_SPARE_CODE_AS_K: assert property (@(posedge clk) disable iff (reset)
    measValid && sensorType > SENSOR_S && $signed(measTenths) > 16'sh3F5C
    |=> wordValue == 16'h7FFF && wordBand == BAND_OVERFLOW)
    else $error("spare type code not treated as type K");

  // main scenarios to be seen at least once
  COV_OVERFLOW: cover property (@(posedge clk) wordValid && wordBand == BAND_OVERFLOW);
  COV_UNDERFLOW: cover property (@(posedge clk) wordValid && wordBand == BAND_UNDERFLOW);
  COV_UNDERRANGE: cover property (@(posedge clk) wordValid && wordBand == BAND_UNDERRANGE);
  COV_BACK2BACK: cover property (@(posedge clk) wordValid ##1 wordValid);
  COV_OVERRANGE: cover property (@(posedge clk) wordValid && wordBand == BAND_OVERRANGE);
endmodule
`default_nettype wire

// [test/tc_front_end.sv]
// converter front end model feeding measurements to the encoder
`timescale 1ns/1ps
`default_nettype none
module tc_front_end
  import tc_range_pkg::*;
(
  // clock
  input  wire logic        clk,
  // measurement towards the encoder
  output var  sensor_t     sensorType,
  output var  logic        measValid,
  output var  logic [15:0] measTenths
);
  // idle at time zero
  initial begin
    sensorType = SENSOR_K;
    measValid  = 1'b0;
    measTenths = 16'h0000;
  end
  // one word per edge, type travels with it
  task automatic send(input sensor_t st, input logic [15:0] v, input bit last);
    @(posedge clk);
    sensorType <= st;
    measValid  <= 1'b1;
    measTenths <= v;
    if (last) begin
      @(posedge clk);
      measValid  <= 1'b0;
      // released data no longer shows the last word
      measTenths <= ~v;
    end
  endtask
endmodule
`default_nettype wire

// [test/thermocouple_value_range_encoder_test.sv]
// self-checking bench for the thermocouple value range encoder
`timescale 1ns/1ps
`default_nettype none
module thermocouple_value_range_encoder_test;
  import tc_range_pkg::*;
  logic        clk;
  logic        reset;
  sensor_t     sensorType;
  logic        measValid;
  logic [15:0] measTenths;
  logic        wordValid;
  logic [15:0] wordValue;
  band_t       wordBand;
  int          fails;
  int          tests_run;
  // per type: overflow above, overrange above, underrange at or below, underflow below
  int lim [5][4] = '{'{16220, 13720, -2701, -3900}, '{11500, 9000, -2001, -3200},
                     '{15500, 13000, -2701, -3900}, '{20190, 17690, -501, -1700},
                     '{18500, 17690, -501, -1700}};
  logic [18:0] pend [$]; // expected band and word, one per taken sample
  tc_front_end tc_front_end_i (.clk(clk), .sensorType(sensorType), .measValid(measValid),
                               .measTenths(measTenths));
  tc_value_encoder tc_value_encoder_i (.clk(clk), .reset(reset), .sensorType(sensorType),
    .measValid(measValid), .measTenths(measTenths), .wordValid(wordValid),
    .wordValue(wordValue), .wordBand(wordBand));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // strobe comparison, counted
  task automatic cmp_valid(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: strobe %b expected %b", $time, got, exp);
    end
  endtask
  // word comparison, counted
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  // band comparison, counted
  task automatic cmp_band(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: band %0d expected %0d", $time, got, exp);
    end
  endtask
  // reference: each saturation checked before the band next to it, values otherwise pass unchanged
  function automatic logic [18:0] model(input int t, input int v);
    if (t > 4) t = 0; // spare type codes are treated as type K
    if (v > lim[t][0]) return {BAND_OVERFLOW, 16'h7FFF};
    if (v > lim[t][1]) return {BAND_OVERRANGE, 16'(v)};
    if (v < lim[t][3]) return {BAND_UNDERFLOW, 16'h8000};
    if (v <= lim[t][2]) return {BAND_UNDERRANGE, 16'(v)};
    return {BAND_RATED, 16'(v)};
  endfunction
  // answer due exactly one edge after each taken sample; looked at mid-cycle, where both
  // the registered outputs and the inputs for the next edge have settled
  always @(negedge clk) begin
    if (pend.size() != 0) begin
      cmp_valid(wordValid, 1'b1);
      cmp_word(wordValue, pend[0][15:0]);
      cmp_band(wordBand, pend[0][18:16]);
      void'(pend.pop_front());
    end else if (reset === 1'b0) cmp_valid(wordValid, 1'b0);
    if (reset === 1'b0 && measValid === 1'b1)
      pend.push_back(model(int'(sensorType), $signed(measTenths)));
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // boundaries of every type back to back, then random traffic
  initial begin
    int pts [10];
    reset = 1'b1;
    fails = 0;
    tests_run = 0;
    void'($urandom(32'h7caa));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (int t = 0; t < 5; t++) begin
      pts = '{lim[t][0] + 1, lim[t][0], lim[t][1] + 1, lim[t][1], lim[t][2] + 1,
              lim[t][2], lim[t][3], lim[t][3] - 1, 32767, -32768};
      foreach (pts[i]) tc_front_end_i.send(sensor_t'(t), 16'(pts[i]), i == 9);
      repeat (3) @(posedge clk);
      $display("boundary test for type %0d done", t);
    end
    // reset in mid-run, with a saturated word still standing: outputs return to idle
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    cmp_word(wordValue, 16'h0000);
    cmp_band(wordBand, BAND_RATED);
    $display("reset test done");
    // random traffic, spare type codes 5 to 7 included
    for (int i = 0; i < 200; i++)
      tc_front_end_i.send(sensor_t'($urandom_range(7)), 16'($urandom), i == 199);
    repeat (3) @(posedge clk);
    $display("random test done");
    end_of_test();
  end
endmodule
`default_nettype wire
